// ### brake_pkg.sv
// Purpose: constants for the hoist brake sequencer
// Assumes: 10 MHz core clock, APB register access
// Notes: times are in 0.1 s steps, frequencies in 0.1 Hz, levels in percent
package brake_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int STEP_PERIOD_NS = 100000000;
    localparam int STEP_CYCLES = STEP_PERIOD_NS / CLK_PERIOD_NS;
    localparam int CUR_FILT_CYCLES = 16;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SELECT = 8'h00;
    localparam logic [7:0] OFS_REL_CUR = 8'h04;
    localparam logic [7:0] OFS_REL_FREQ = 8'h08;
    localparam logic [7:0] OFS_REL_TORQ = 8'h0c;
    localparam logic [7:0] OFS_REL_TIME = 8'h10;
    localparam logic [7:0] OFS_APP_FREQ = 8'h14;
    localparam logic [7:0] OFS_APP_TIME = 8'h18;
    localparam logic [7:0] OFS_STOP_FREQ = 8'h1c;
    localparam logic [7:0] OFS_TERM_FUNC = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    // ------------------------------------------------------------
    // select field positions
    // ------------------------------------------------------------
    localparam int SEL_SPEED_SRC = 0;
    localparam int SEL_QUICK = 2;
    localparam int SEL_FREQ_SRC = 3;
    localparam int SEL_RUN_GATE = 4;
    // ------------------------------------------------------------
    // reset values and fixed codes
    // ------------------------------------------------------------
    localparam logic [4:0] RST_SELECT = 5'h00;
    localparam logic [8:0] RST_REL_CUR = 9'h064;
    localparam logic [7:0] RST_REL_FREQ = 8'h0a;
    localparam logic [8:0] RST_REL_TORQ = 9'h064;
    localparam logic [5:0] RST_REL_TIME = 6'h0a;
    localparam logic [7:0] RST_APP_FREQ = 8'h0a;
    localparam logic [5:0] RST_APP_TIME = 6'h0a;
    localparam logic [7:0] RST_STOP_FREQ = 8'h05;
    localparam logic [7:0] RST_TERM_FUNC = 8'h00;
    localparam logic [7:0] BRAKE_FUNC_CODE = 8'h39;
    localparam logic [6:0] PCT_FULL = 7'h64;

    typedef enum logic [1:0] {
        BRAKE_APPLIED = 2'b01,
        BRAKE_RELEASED = 2'b10
    } brake_state_e;
endpackage

// ### hoist_brake_sequencer.sv
// Purpose: brake release/apply decision for a hoisting drive, APB slave
// Assumes: all inputs synchronous to core_clk
// Notes: forced states hold the brake applied (release command low)
//
// Functional notes
// RQ1: release after current, frequency or torque stays above level for release delay.
// RQ2: current level is 0..300 percent of rated current of chosen duty.
// RQ3: release frequency level only counts under volts-per-hertz control.
// RQ4: release torque level only counts under vector control.
// RQ5: response bit 0 filters current detection, 1 detects unfiltered.
// RQ6: volts-per-hertz: apply when run off and frequency below level for delay.
// RQ7: vector: apply when chosen speed below chosen level for apply delay.
// RQ8: speed bit: 0 detected speed, 1 reference speed.
// RQ9: sensorless vector control needs speed bit set to reference speed.
// RQ10: frequency bit: 0 stop frequency, 1 brake-apply frequency.
// RQ11: run bit: 0 ignores run command, 1 apply only with run off.
// RQ12: set run bit when forward and reverse are switched.
// RQ13: output shutdown during apply delay applies the brake at once.
// RQ14: motors two to four hold the brake in the forced state.
// RQ15: alarm or coast-to-stop forces the brake state immediately.
// RQ16: terminal shows command only when its function equals brake code.
// RQ17: delay counts restart from zero when their condition lapses.
`timescale 1ns/10ps
module hoist_brake_sequencer
    import brake_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYCLES,
    parameter int FILT_CYC = CUR_FILT_CYCLES,
    parameter logic [15:0] RATED_HEAVY = 16'h0064,
    parameter logic [15:0] RATED_LIGHT = 16'h0078
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // drive state
    input wire logic runCmd,
    input wire logic vectorMode,
    input wire logic lightDuty,
    input wire logic outputShutdown,
    input wire logic alarmTrip,
    input wire logic coastCmd,
    input wire logic [1:0] motorSel,
    input wire logic [15:0] outCurrent,
    input wire logic [15:0] outFreq,
    input wire logic [15:0] torqueCmd,
    input wire logic [15:0] detSpeed,
    input wire logic [15:0] refSpeed,
    // brake
    output logic brakeReleaseCmd,
    output logic brakeTerminal
);
    localparam int SW = $clog2(STEP_CYC + 1);
    localparam int FW = $clog2(FILT_CYC + 1);

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    logic [4:0] select_reg, select_next;
    logic [8:0] relCur_reg, relCur_next;
    logic [7:0] relFreq_reg, relFreq_next;
    logic [8:0] relTorq_reg, relTorq_next;
    logic [5:0] relTime_reg, relTime_next;
    logic [7:0] appFreq_reg, appFreq_next;
    logic [5:0] appTime_reg, appTime_next;
    logic [7:0] stopFreq_reg, stopFreq_next;
    logic [7:0] termFunc_reg, termFunc_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [3:0] status;
    logic relCounting, appCounting;

    function automatic logic mapped(input logic [7:0] a);
        return a <= OFS_STATUS && a[1:0] == 2'b00;
    endfunction

    always_comb begin
        select_next = select_reg;
        relCur_next = relCur_reg;
        relFreq_next = relFreq_reg;
        relTorq_next = relTorq_reg;
        relTime_next = relTime_reg;
        appFreq_next = appFreq_reg;
        appTime_next = appTime_reg;
        stopFreq_next = stopFreq_reg;
        termFunc_next = termFunc_reg;
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        pready_next = psel && penable && !pready_reg;
        if (psel && penable && !pready_reg) begin
            pslverr_next = !mapped(paddr);
            prdata_next = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    OFS_SELECT: prdata_next = {27'h0, select_reg};
                    OFS_REL_CUR: prdata_next = {23'h0, relCur_reg};
                    OFS_REL_FREQ: prdata_next = {24'h0, relFreq_reg};
                    OFS_REL_TORQ: prdata_next = {23'h0, relTorq_reg};
                    OFS_REL_TIME: prdata_next = {26'h0, relTime_reg};
                    OFS_APP_FREQ: prdata_next = {24'h0, appFreq_reg};
                    OFS_APP_TIME: prdata_next = {26'h0, appTime_reg};
                    OFS_STOP_FREQ: prdata_next = {24'h0, stopFreq_reg};
                    OFS_TERM_FUNC: prdata_next = {24'h0, termFunc_reg};
                    OFS_STATUS: prdata_next = {28'h0, status};
                    default: prdata_next = 32'h0000_0000;
                endcase
            end
        end
        // write lands on the edge that samples pready high
        if (psel && penable && pready_reg && pwrite) begin
            unique case (paddr)
                OFS_SELECT: select_next = {pwdata[4:2], 1'b0, pwdata[0]};
                OFS_REL_CUR: relCur_next = pwdata[8:0];
                OFS_REL_FREQ: relFreq_next = pwdata[7:0];
                OFS_REL_TORQ: relTorq_next = pwdata[8:0];
                OFS_REL_TIME: relTime_next = pwdata[5:0];
                OFS_APP_FREQ: appFreq_next = pwdata[7:0];
                OFS_APP_TIME: appTime_next = pwdata[5:0];
                OFS_STOP_FREQ: stopFreq_next = pwdata[7:0];
                OFS_TERM_FUNC: termFunc_next = pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            select_reg <= RST_SELECT;
            relCur_reg <= RST_REL_CUR;
            relFreq_reg <= RST_REL_FREQ;
            relTorq_reg <= RST_REL_TORQ;
            relTime_reg <= RST_REL_TIME;
            appFreq_reg <= RST_APP_FREQ;
            appTime_reg <= RST_APP_TIME;
            stopFreq_reg <= RST_STOP_FREQ;
            termFunc_reg <= RST_TERM_FUNC;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            select_reg <= select_next;
            relCur_reg <= relCur_next;
            relFreq_reg <= relFreq_next;
            relTorq_reg <= relTorq_next;
            relTime_reg <= relTime_next;
            appFreq_reg <= appFreq_next;
            appTime_reg <= appTime_next;
            stopFreq_reg <= stopFreq_next;
            termFunc_reg <= termFunc_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ------------------------------------------------------------
    // conditions
    // ------------------------------------------------------------
    logic [31:0] curScaled, curLimit;
    logic curAbove, curDet, relCond, appCond, forceApply;
    logic [15:0] cmpSpeed, cmpLevel;

    assign curScaled = outCurrent * {9'h0, PCT_FULL};
    assign curLimit = (lightDuty ? RATED_LIGHT : RATED_HEAVY) * {7'h0, relCur_reg}; // RQ2
    assign curAbove = curScaled > curLimit;
    assign cmpSpeed = select_reg[SEL_SPEED_SRC] ? refSpeed : detSpeed; // RQ8
    assign cmpLevel = {8'h0, select_reg[SEL_FREQ_SRC] ? appFreq_reg : stopFreq_reg}; // RQ10
    assign forceApply = alarmTrip || coastCmd || motorSel != 2'b00; // RQ14 RQ15

    always_comb begin
        relCond = curDet;
        if (vectorMode) begin
            relCond = relCond || torqueCmd > {7'h0, relTorq_reg}; // RQ4
            appCond = cmpSpeed < cmpLevel && !(select_reg[SEL_RUN_GATE] && runCmd); // RQ7 RQ11
        end else begin
            relCond = relCond || outFreq > {8'h0, relFreq_reg}; // RQ3
            appCond = !runCmd && outFreq < {8'h0, appFreq_reg}; // RQ6
        end
    end

    // ------------------------------------------------------------
    // current detection filter and step divider
    // ------------------------------------------------------------
    logic [FW-1:0] filtCnt_reg, filtCnt_next;
    logic [SW-1:0] div_reg, div_next;
    logic step;

    assign step = div_reg == SW'(STEP_CYC - 1);

    always_comb begin
        div_next = step ? '0 : div_reg + 1'b1;
        filtCnt_next = '0;
        if (curAbove && filtCnt_reg != FW'(FILT_CYC)) begin
            filtCnt_next = filtCnt_reg + 1'b1;
        end else if (curAbove) begin
            filtCnt_next = filtCnt_reg;
        end
        // slow response waits for a stable rise, quick takes it raw
        curDet = select_reg[SEL_QUICK] ? curAbove : filtCnt_reg == FW'(FILT_CYC); // RQ5
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg <= '0;
            filtCnt_reg <= '0;
        end else begin
            div_reg <= div_next;
            filtCnt_reg <= filtCnt_next;
        end
    end

    // ------------------------------------------------------------
    // brake state machine
    // ------------------------------------------------------------
    brake_state_e state_reg, state_next;
    logic [5:0] relCnt_reg, relCnt_next;
    logic [5:0] appCnt_reg, appCnt_next;
    logic term_reg, term_next;

    always_comb begin
        state_next = state_reg;
        relCnt_next = '0;
        appCnt_next = '0;
        unique case (state_reg)
            BRAKE_APPLIED: begin
                if (!forceApply && !outputShutdown && relCond) begin
                    // the first step pulse may fall early, so one pulse more closes the full delay
                    if (relCnt_reg >= relTime_reg && (step || relTime_reg == 6'h00)) begin
                        state_next = BRAKE_RELEASED; // RQ1
                    end else begin
                        relCnt_next = relCnt_reg + 6'(step); // RQ17
                    end
                end
            end
            BRAKE_RELEASED: begin
                if (forceApply || outputShutdown) begin
                    state_next = BRAKE_APPLIED; // RQ13 RQ15
                end else if (appCond) begin
                    if (appCnt_reg >= appTime_reg && (step || appTime_reg == 6'h00)) begin
                        state_next = BRAKE_APPLIED; // RQ6 RQ7
                    end else begin
                        appCnt_next = appCnt_reg + 6'(step); // RQ17
                    end
                end
            end
            default: state_next = BRAKE_APPLIED;
        endcase
        term_next = state_next == BRAKE_RELEASED && termFunc_reg == BRAKE_FUNC_CODE; // RQ16
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= BRAKE_APPLIED;
            relCnt_reg <= '0;
            appCnt_reg <= '0;
            term_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            relCnt_reg <= relCnt_next;
            appCnt_reg <= appCnt_next;
            term_reg <= term_next;
        end
    end

    assign brakeReleaseCmd = state_reg[1];
    assign brakeTerminal = term_reg;
    assign relCounting = relCnt_reg != 6'h00;
    assign appCounting = appCnt_reg != 6'h00;
    assign status = {term_reg, appCounting, relCounting, brakeReleaseCmd};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_force_apply: assert property ((alarmTrip || coastCmd) |=> !brakeReleaseCmd) // RQ15
        else $error("brake not applied on alarm or coast");
    chk_motor_hold: assert property (motorSel != 2'b00 |=> !brakeReleaseCmd && !brakeTerminal) // RQ14
        else $error("brake released for motor other than first");
    chk_shutdown_abort: assert property (brakeReleaseCmd && outputShutdown |=> !brakeReleaseCmd) // RQ13
        else $error("apply delay not abandoned on shutdown");
    chk_release_cause: assert property ($rose(brakeReleaseCmd) |-> $past(relCond) && $past(relCnt_reg) >= $past(relTime_reg)) // RQ1
        else $error("release without qualified delay");
    chk_apply_cause: assert property ($fell(brakeReleaseCmd) |-> $past(appCond || forceApply || outputShutdown)) // RQ6 RQ7
        else $error("apply without cause");
    chk_run_gate: assert property (brakeReleaseCmd && runCmd && (!vectorMode || select_reg[SEL_RUN_GATE])
        && !forceApply && !outputShutdown |=> brakeReleaseCmd) // RQ6 RQ11
        else $error("apply while run command on");
    chk_count_restart: assert property (!brakeReleaseCmd && !relCond |=> relCnt_reg == 6'h00) // RQ17
        else $error("release count kept after lapse");
    chk_terminal_gate: assert property (brakeTerminal |-> brakeReleaseCmd && $past(termFunc_reg) == BRAKE_FUNC_CODE) // RQ16
        else $error("terminal active without brake function");
    chk_filter_lag: assert property (!select_reg[SEL_QUICK] && $rose(curAbove) |-> !curDet) // RQ5
        else $error("slow response did not filter");
endmodule

// ### brake_model.sv
// Purpose: behavioural mechanical brake behind the brake output terminal
// Assumes: terminal high energises the release coil
// Notes: shoes lift only after the coil has stayed energised for LAG cycles
`timescale 1ns/10ps
module brake_model #(
    parameter int LAG = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // coil drive and shoe state
    input wire logic brakeTerminal,
    output logic brakeOpen
);
    int holdCnt;
    // a dropped coil clamps the shoes at once, so a short pulse never lifts them
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst || !brakeTerminal) begin
            holdCnt <= 0;
            brakeOpen <= 1'b0;
        end else if (holdCnt < LAG) begin
            holdCnt <= holdCnt + 1;
        end else begin
            brakeOpen <= 1'b1;
        end
    end
endmodule

// ### tb_top.sv
// Purpose: self-checking bench for the hoist brake sequencer
// Assumes: short step divider so delay counts stay brief
// Notes: every brake output change is matched against a queued note
`timescale 1ns/10ps
module tb_top;
    import brake_pkg::*;
    localparam int STEP = 10;
    localparam int FILT = 16;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic runCmd = 1'b1, vectorMode = 1'b0, lightDuty = 1'b1, outputShutdown = 1'b0, alarmTrip = 1'b0;
    logic coastCmd = 1'b0;
    logic [1:0] motorSel = 2'h0;
    logic [15:0] outCurrent = 16'h0, outFreq = 16'h0, torqueCmd = 16'h0, detSpeed = 16'h0, refSpeed = 16'h0;
    logic [31:0] prdata;
    logic pready, pslverr, brakeReleaseCmd, brakeTerminal, brakeOpen;
    int failures = 0, num_checks = 0, cyc = 0, seed = 32'h1458;
    logic [33:0] apbQ[$];
    logic [1:0] brkQ[$];
    logic [33:0] note;
    logic [1:0] lastBrk = 2'h0;
    logic termOn = 1'b0;
    logic [7:0] ofs [8] = '{OFS_REL_CUR, OFS_REL_FREQ, OFS_REL_TORQ, OFS_REL_TIME, OFS_APP_FREQ,
        OFS_APP_TIME, OFS_STOP_FREQ, OFS_TERM_FUNC};
    logic [31:0] rv [8] = '{32'(RST_REL_CUR), 32'(RST_REL_FREQ), 32'(RST_REL_TORQ), 32'(RST_REL_TIME),
        32'(RST_APP_FREQ), 32'(RST_APP_TIME), 32'(RST_STOP_FREQ), 32'(RST_TERM_FUNC)};

    always #50 core_clk = ~core_clk;

    hoist_brake_sequencer #(.STEP_CYC(STEP), .FILT_CYC(FILT)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .runCmd(runCmd), .vectorMode(vectorMode), .lightDuty(lightDuty),
        .outputShutdown(outputShutdown), .alarmTrip(alarmTrip), .coastCmd(coastCmd), .motorSel(motorSel),
        .outCurrent(outCurrent), .outFreq(outFreq), .torqueCmd(torqueCmd), .detSpeed(detSpeed),
        .refSpeed(refSpeed), .brakeReleaseCmd(brakeReleaseCmd), .brakeTerminal(brakeTerminal));
    brake_model u_brake (.core_clk(core_clk), .sys_rst(sys_rst), .brakeTerminal(brakeTerminal),
        .brakeOpen(brakeOpen));

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            final_report();
        end
    end

    // results are taken at the edge where they stand
    always @(posedge core_clk) begin
        if (!sys_rst && pready === 1'b1) begin
            note = (apbQ.size() > 0) ? apbQ.pop_front() : 34'h3ffffffff;
            chk(32'(pslverr), 32'(note[32]));
            if (note[33]) chk(prdata, note[31:0]);
        end
        if (!sys_rst && {brakeTerminal, brakeReleaseCmd} !== lastBrk) begin
            lastBrk = {brakeTerminal, brakeReleaseCmd};
            chk(32'(lastBrk), (brkQ.size() > 0) ? 32'(brkQ.pop_front()) : 32'hffffffff);
        end
    end

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err,
        input logic [31:0] exp);
        apbQ.push_back({~w, err, exp});
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic expectBrk(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        brkQ.push_back({v & termOn, v});
        do begin
            @(posedge core_clk);
            n++;
        end while (brakeReleaseCmd !== v && n < 2000);
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask

    task automatic setForce(input int k);
        @(posedge core_clk);
        alarmTrip <= (k == 0);
        coastCmd <= (k == 1);
        motorSel <= (k >= 2 && k <= 4) ? 2'(k - 1) : 2'h0;
        outputShutdown <= (k == 5);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        apb(1'b0, OFS_SELECT, 32'h0, 1'b0, 32'(RST_SELECT));
        for (int i = 0; i < 8; i++) apb(1'b0, ofs[i], 32'h0, 1'b0, rv[i]);
        apb(1'b0, 8'h28, 32'h0, 1'b1, 32'h0);
        apb(1'b1, 8'h2a, 32'hff, 1'b1, 32'h0);
        apb(1'b1, OFS_SELECT, 32'h1f, 1'b0, 32'h0);
        apb(1'b0, OFS_SELECT, 32'h0, 1'b0, 32'h1d);
        apb(1'b1, OFS_SELECT, 32'h4, 1'b0, 32'h0);
        apb(1'b1, OFS_REL_TIME, 32'h0, 1'b0, 32'h0);
        apb(1'b1, OFS_TERM_FUNC, 32'(BRAKE_FUNC_CODE), 1'b0, 32'h0);
        termOn = 1'b1;
        // light duty raises rated current, so 110 is not above the level
        @(posedge core_clk);
        outCurrent <= 16'h6e;
        repeat (30) @(posedge core_clk);
        lightDuty <= 1'b0;
        expectBrk(1'b1, 1, 4);
        repeat (4) @(posedge core_clk);
        chk(32'(brakeOpen), 32'h1);
        for (int k = 0; k < 6; k++) begin
            setForce(k);
            expectBrk(1'b0, 1, 3);
            setForce(9);
            expectBrk(1'b1, 1, 4);
        end
        setForce(0);
        expectBrk(1'b0, 1, 3);
        apb(1'b1, OFS_REL_TIME, 32'h3, 1'b0, 32'h0);
        outCurrent <= 16'h0;
        setForce(9);
        outCurrent <= 16'h65 + 16'($unsigned($random(seed)) % 200);
        repeat (2 * STEP) @(posedge core_clk);
        outCurrent <= 16'h64;
        @(posedge core_clk);
        outCurrent <= 16'h65 + 16'($unsigned($random(seed)) % 200);
        expectBrk(1'b1, 3 * STEP, 4 * STEP + 4);
        setForce(0);
        expectBrk(1'b0, 1, 3);
        outCurrent <= 16'h0;
        apb(1'b1, OFS_SELECT, 32'h0, 1'b0, 32'h0);
        apb(1'b1, OFS_REL_TIME, 32'h0, 1'b0, 32'h0);
        apb(1'b1, OFS_APP_TIME, 32'h2, 1'b0, 32'h0);
        setForce(9);
        outCurrent <= 16'h65 + 16'($unsigned($random(seed)) % 200);
        expectBrk(1'b1, FILT, FILT + STEP + 4);
        outCurrent <= 16'h0;
        outFreq <= 16'h5;
        repeat (4 * STEP) @(posedge core_clk);
        runCmd <= 1'b0;
        expectBrk(1'b0, 2 * STEP, 3 * STEP + 4);
        vectorMode <= 1'b1;
        outFreq <= 16'hc8;
        repeat (3 * STEP) @(posedge core_clk);
        vectorMode <= 1'b0;
        expectBrk(1'b1, 1, 4);
        outFreq <= 16'h0;
        expectBrk(1'b0, 2 * STEP, 3 * STEP + 4);
        torqueCmd <= 16'h96;
        detSpeed <= 16'hc8;
        refSpeed <= 16'hc8;
        repeat (3 * STEP) @(posedge core_clk);
        vectorMode <= 1'b1;
        expectBrk(1'b1, 1, 4);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_SELECT, 32'({i[0], i[1], 1'b1, 1'b0, i[0]}), 1'b0, 32'h0);
            runCmd <= 1'b1;
            torqueCmd <= 16'h0;
            detSpeed <= i[0] ? 16'hc8 + 16'($unsigned($random(seed)) % 99) : (i[1] ? 16'h7 : 16'h3);
            refSpeed <= i[0] ? (i[1] ? 16'h7 : 16'h3) : 16'hc8 + 16'($unsigned($random(seed)) % 99);
            // without run gating the apply must come with the run command still on
            if (i[0]) begin
                repeat (4 * STEP) @(posedge core_clk);
                runCmd <= 1'b0;
            end
            expectBrk(1'b0, 2 * STEP, 3 * STEP + 4);
            detSpeed <= 16'hc8;
            refSpeed <= 16'hc8;
            torqueCmd <= 16'h96;
            expectBrk(1'b1, 1, 4);
        end
        apb(1'b1, OFS_APP_TIME, 32'h5, 1'b0, 32'h0);
        vectorMode <= 1'b0;
        torqueCmd <= 16'h0;
        repeat (STEP) @(posedge core_clk);
        outputShutdown <= 1'b1;
        expectBrk(1'b0, 1, 3);
        outputShutdown <= 1'b0;
        apb(1'b1, OFS_TERM_FUNC, 32'(BRAKE_FUNC_CODE ^ (8'h1 | 8'($random(seed)))), 1'b0, 32'h0);
        termOn = 1'b0;
        runCmd <= 1'b1;
        outCurrent <= 16'h65;
        expectBrk(1'b1, 1, FILT + STEP + 4);
        repeat (10) @(posedge core_clk);
        chk(32'(brakeOpen), 32'h0);
        final_report();
    end
endmodule
